// ---- hw/hprsc_top.sv ----
// Permit gating, proving wait, relays and target selection
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Fire only with both permits closed
// - Remote permit enables or stops unit
// - Proven permit checked during purge and fire
// - Proving wait settable 0 to 240 s
// - Wait expired unproven aborts start
// - Fault relay latched until clear pressed
// - Helper relay follows heat demand while remote permit closed
// - Serial pins usable only switch on
// - Local target limited 40 to 240 F
// - Selection picks fixed or external target
// - Source offset, zero or network; default offset
// - Offset range: low end maps 40 F
// - Zero range: zero maps 40 F
// - Remote indicator lit in remote mode when signal present
// - Toggle alternates manual and remote modes
// - Linear level mapping, no scaling
module hprsc_top #(
    parameter int unsigned SEC_CYC = hprsc_pkg::SEC_CYCLES
) (
    // Clock, reset, enable
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic ce_in,
    // Field pins
    input wire logic remote_permit_in,
    input wire logic proven_permit_in,
    input wire logic auto_manual_toggle_in,
    input wire logic clear_button_in,
    input wire logic fault_in,
    input wire logic heat_demand_in,
    input wire logic purge_done_in,
    // Configuration and external target
    input wire hprsc_pkg::hprsc_cfg_type cfg_in,
    input wire hprsc_pkg::hprsc_ext_type ext_in,
    input wire logic serial_rx_in,
    input wire logic serial_tx_data_in,
    // Outputs
    output logic fire_permit_out,
    output logic unit_enabled_out,
    output logic proving_abort_out,
    output logic fault_relay_out,
    output logic helper_relay_out,
    output logic remote_led_out,
    output logic manual_led_out,
    output logic [7:0] target_out,
    output logic serial_tx_out,
    output logic serial_rx_out
);
    import hprsc_pkg::*;

    logic rst_a;
    logic rst_n;
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rst_a <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_a <= 1'b1;
            rst_n <= rst_a;
        end
    end

    // Three-stage pin synchronisers
    localparam int NP = 7;
    logic [NP-1:0] pins;
    logic [NP-1:0] s1, s2, s3, filt, next_filt;
    assign pins = {remote_permit_in, proven_permit_in, auto_manual_toggle_in,
                   clear_button_in, fault_in, heat_demand_in, purge_done_in};
    always_comb begin
        next_filt = filt;
        for (int i = 0; i < NP; i++) begin
            if (s2[i] == s3[i]) begin
                next_filt[i] = s3[i];
            end
        end
    end
    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            filt <= '0;
        end else if (ce_in) begin
            s1 <= pins;
            s2 <= s1;
            s3 <= s2;
            filt <= next_filt;
        end
    end
    logic remote_ok, proven_ok, toggle_lvl, clear_lvl, fault_lvl;
    logic demand_lvl, purge_done;
    assign {remote_ok, proven_ok, toggle_lvl, clear_lvl, fault_lvl,
            demand_lvl, purge_done} = filt;

    // Start sequence
    hprsc_state_type state, next_state;
    logic [31:0] tick, next_tick;
    logic [7:0] secs, next_secs;
    logic [7:0] wait_lim;
    logic abort, next_abort;
    logic fault_latch, next_fault_latch;
    always_comb begin
        wait_lim = (cfg_in.prove_wait > PROVE_WAIT_MAX) ? PROVE_WAIT_MAX
                   : cfg_in.prove_wait;
        next_state = state;
        next_tick = tick;
        next_secs = secs;
        next_abort = abort;
        case (state)
            HPRSC_ST_IDLE: begin
                next_tick = '0;
                next_secs = '0;
                if (remote_ok && demand_lvl && !fault_latch) begin
                    next_state = HPRSC_ST_PURGE;
                    next_abort = 1'b0;
                end
            end
            HPRSC_ST_PURGE: begin
                if (!remote_ok || !demand_lvl) begin
                    next_state = HPRSC_ST_IDLE;
                end else if (proven_ok) begin
                    if (purge_done) begin
                        next_state = HPRSC_ST_FIRE;
                    end
                end else if (secs >= wait_lim) begin
                    next_state = HPRSC_ST_ABORT;
                    next_abort = 1'b1;
                end else if (tick == SEC_CYC - 1) begin
                    next_tick = '0;
                    next_secs = secs + 8'h01;
                end else begin
                    next_tick = tick + 32'h1;
                end
            end
            HPRSC_ST_FIRE: begin
                if (!remote_ok || !proven_ok || !demand_lvl) begin
                    next_state = HPRSC_ST_IDLE;
                end
            end
            HPRSC_ST_ABORT: begin
                if (!demand_lvl || !remote_ok) begin
                    next_state = HPRSC_ST_IDLE;
                end
            end
            default: next_state = HPRSC_ST_IDLE;
        endcase
    end
    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            state <= HPRSC_ST_IDLE;
            tick <= '0;
            secs <= PROVE_WAIT_RST;
            abort <= 1'b0;
        end else if (ce_in) begin
            state <= next_state;
            tick <= next_tick;
            secs <= next_secs;
            abort <= next_abort;
        end
    end

    // Fault latch, mode toggle
    logic remote_mode, next_remote_mode, toggle_d, mode_init;
    logic next_mode_init;
    always_comb begin
        next_fault_latch = fault_latch;
        // Abort state sets the fault latch, held until clear
        if (fault_lvl || (state == HPRSC_ST_ABORT)) begin
            next_fault_latch = 1'b1;
        end else if (clear_lvl) begin
            next_fault_latch = 1'b0;
        end
        next_mode_init = 1'b1;
        next_remote_mode = remote_mode;
        if (!mode_init) begin
            next_remote_mode = cfg_in.remote_mode;
        end else if (toggle_lvl && !toggle_d) begin
            next_remote_mode = !remote_mode;
        end
    end
    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            fault_latch <= 1'b0;
            remote_mode <= 1'b0;
            toggle_d <= 1'b0;
            mode_init <= 1'b0;
        end else if (ce_in) begin
            fault_latch <= next_fault_latch;
            remote_mode <= next_remote_mode;
            toggle_d <= toggle_lvl;
            mode_init <= next_mode_init;
        end
    end

    // Target selection
    logic [7:0] analog_target;
    hprsc_level_map u_map (
        .clk_in(core_clk_in),
        .rst_n_in(rst_n),
        .ce_in(ce_in),
        .source_in(cfg_in.source),
        .level_in(ext_in.level),
        .target_out(analog_target)
    );
    logic [7:0] local_t, ext_t, next_target;
    logic ext_present, next_remote_led;
    always_comb begin
        local_t = cfg_in.local_target;
        if (local_t < TEMP_MIN_F) begin
            local_t = TEMP_MIN_F;
        end else if (local_t > TEMP_MAX_F) begin
            local_t = TEMP_MAX_F;
        end
        ext_t = (cfg_in.source == HPRSC_SRC_NET) ? ext_in.net_target
                : analog_target;
        if (ext_t < TEMP_MIN_F) begin
            ext_t = TEMP_MIN_F;
        end else if (ext_t > TEMP_MAX_F) begin
            ext_t = TEMP_MAX_F;
        end
        ext_present = (cfg_in.source == HPRSC_SRC_NET) ? ext_in.net_valid
                      : ext_in.level_valid;
        next_target = (remote_mode && ext_present) ? ext_t : local_t;
        next_remote_led = remote_mode && ext_present;
    end

    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            fire_permit_out <= 1'b0;
            unit_enabled_out <= 1'b0;
            proving_abort_out <= 1'b0;
            fault_relay_out <= 1'b0;
            helper_relay_out <= 1'b0;
            remote_led_out <= 1'b0;
            manual_led_out <= 1'b1;
            target_out <= LOCAL_TARGET_RST;
            serial_tx_out <= 1'b1;
            serial_rx_out <= 1'b1;
        end else if (ce_in) begin
            fire_permit_out <= (state == HPRSC_ST_FIRE) && remote_ok
                               && proven_ok;
            unit_enabled_out <= remote_ok;
            proving_abort_out <= abort;
            fault_relay_out <= next_fault_latch;
            helper_relay_out <= demand_lvl && remote_ok;
            remote_led_out <= next_remote_led;
            manual_led_out <= !next_remote_mode;
            target_out <= next_target;
            serial_tx_out <= cfg_in.serial_port_switch ? serial_tx_data_in
                             : 1'b1;
            serial_rx_out <= cfg_in.serial_port_switch ? serial_rx_in
                             : 1'b1;
        end
    end
endmodule
`default_nettype wire

// ---- common/hprsc_pkg.sv ----
// Package: constants and carrier types for the permit/relay/setpoint block
package hprsc_pkg;
    localparam int unsigned CLK_HZ = 10000000;
    localparam int unsigned SEC_TIME = 1;
    localparam int unsigned SEC_CYCLES = SEC_TIME * CLK_HZ;
    localparam logic [7:0] PROVE_WAIT_MAX = 8'hf0;
    localparam logic [7:0] PROVE_WAIT_RST = 8'h00;
    localparam logic [7:0] TEMP_MIN_F = 8'h28;
    localparam logic [7:0] TEMP_MAX_F = 8'hf0;
    localparam logic [7:0] TEMP_SPAN_F = 8'hc8;
    localparam logic [7:0] LOCAL_TARGET_RST = 8'h28;
    localparam logic [11:0] LEVEL_FULL = 12'hfff;
    localparam logic [11:0] LEVEL_OFFSET = 12'h333;
    localparam int unsigned SYNC_STAGES = 3;

    typedef enum logic [1:0] {
        HPRSC_SRC_OFFSET = 2'b00,
        HPRSC_SRC_ZERO = 2'b01,
        HPRSC_SRC_NET = 2'b10
    } hprsc_src_type;

    typedef enum logic [2:0] {
        HPRSC_ST_IDLE = 3'b000,
        HPRSC_ST_PURGE = 3'b001,
        HPRSC_ST_FIRE = 3'b010,
        HPRSC_ST_ABORT = 3'b011
    } hprsc_state_type;

    typedef struct packed {
        logic remote_mode;
        hprsc_src_type source;
        logic [7:0] local_target;
        logic [7:0] prove_wait;
        logic serial_port_switch;
    } hprsc_cfg_type;

    typedef struct packed {
        logic [11:0] level;
        logic level_valid;
        logic [7:0] net_target;
        logic net_valid;
    } hprsc_ext_type;
endpackage

// ---- hw/hprsc_level_map.sv ----
// Analog level to target temperature mapping
`timescale 1ns/1ps
`default_nettype none
module hprsc_level_map (
    // Clock and enable
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    // Level in
    input wire hprsc_pkg::hprsc_src_type source_in,
    input wire logic [11:0] level_in,
    // Target out
    output logic [7:0] target_out
);
    import hprsc_pkg::*;

    logic [7:0] next_target;

    function automatic logic [7:0] map_level(input logic [11:0] lvl,
                                             input logic offs);
        logic [11:0] base;
        logic [11:0] span;
        logic [19:0] prod;
        base = offs ? LEVEL_OFFSET : 12'h000;
        span = LEVEL_FULL - base;
        if (lvl <= base) begin
            map_level = TEMP_MIN_F;
        end else begin
            prod = 20'(lvl - base) * 20'(TEMP_SPAN_F);
            map_level = TEMP_MIN_F + 8'(prod / 20'(span));
        end
    endfunction

    always_comb begin
        // Linear between endpoints, no user scaling
        next_target = map_level(level_in,
            source_in == HPRSC_SRC_OFFSET);
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            target_out <= TEMP_MIN_F;
        end else if (ce_in) begin
            target_out <= next_target;
        end
    end
endmodule
`default_nettype wire

// ---- sim/hprsc_field_model.sv ----
// Proving switch of auxiliary equipment started by the helper relay
`timescale 1ns/1ps
`default_nettype none
module hprsc_field_model (
    // Clock and control
    input wire logic clk_in,
    input wire logic relay_in,
    input wire logic [7:0] delay_in,
    input wire logic stuck_in,
    // Switch contact
    output logic proven_out
);
    logic [7:0] count;
    // Contact makes a set time after the equipment starts
    always_ff @(negedge clk_in) begin
        if (!relay_in) begin
            count <= 8'h00;
        end else if (count != 8'hff) begin
            count <= count + 8'h01;
        end
    end
    assign proven_out = relay_in && !stuck_in && (count >= delay_in);
endmodule
`default_nettype wire

// ---- sim/hprsc_monitor.sv ----
// Checker for permits, relays, target range and serial pins
`timescale 1ns/1ps
`default_nettype none
module hprsc_monitor (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rstn_in,
    // Pins
    input wire logic remote_permit_in,
    input wire logic clear_button_in,
    input wire logic fault_in,
    input wire logic heat_demand_in,
    input wire hprsc_pkg::hprsc_cfg_type cfg_in,
    // Outputs
    input wire logic fire_permit_out,
    input wire logic unit_enabled_out,
    input wire logic proving_abort_out,
    input wire logic fault_relay_out,
    input wire logic helper_relay_out,
    input wire logic [7:0] target_out,
    input wire logic serial_tx_out,
    input wire logic serial_rx_out
);
    import hprsc_pkg::*;
    logic [4:0] age;
    wire ok = &age;
    // Ignores the pin pipeline filling after reset
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) age <= 5'h00;
        else if (!ok) age <= age + 5'h01;
    end
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rstn_in);
    property p_fire;
        (ok && !remote_permit_in)[*8] |-> !fire_permit_out; endproperty
    a_fire: assert property (p_fire) else $error("fire open");
    property p_en;
        (ok && remote_permit_in)[*8] |-> unit_enabled_out; endproperty
    a_en: assert property (p_en) else $error("not enabled");
    property p_abort;
        $rose(proving_abort_out) |-> ##[0:2] fault_relay_out; endproperty
    a_abort: assert property (p_abort) else $error("no fault");
    property p_fault;
        (ok && fault_in)[*8] |-> fault_relay_out; endproperty
    a_fault: assert property (p_fault) else $error("relay off");
    property p_latch;
        (ok && !clear_button_in)[*8] ##0 fault_relay_out |=> fault_relay_out;
    endproperty
    a_latch: assert property (p_latch) else $error("latch drop");
    property p_help;
        (ok && !heat_demand_in)[*8] |-> !helper_relay_out; endproperty
    a_help: assert property (p_help) else $error("helper on");
    property p_ser;
        (!cfg_in.serial_port_switch)[*2] |-> serial_tx_out && serial_rx_out;
    endproperty
    a_ser: assert property (p_ser) else $error("serial on");
    property p_rng;
        target_out >= TEMP_MIN_F && target_out <= TEMP_MAX_F; endproperty
    a_rng: assert property (p_rng) else $error("target range");
    c_fire: cover property ($rose(fire_permit_out));
    c_abort: cover property ($rose(proving_abort_out));
    c_help: cover property ($rose(helper_relay_out));
endmodule
bind hprsc_top hprsc_monitor i_mon (
    .core_clk_in(core_clk_in),
    .rstn_in(rstn_in),
    .remote_permit_in(remote_permit_in),
    .clear_button_in(clear_button_in),
    .fault_in(fault_in),
    .heat_demand_in(heat_demand_in),
    .cfg_in(cfg_in),
    .fire_permit_out(fire_permit_out),
    .unit_enabled_out(unit_enabled_out),
    .proving_abort_out(proving_abort_out),
    .fault_relay_out(fault_relay_out),
    .helper_relay_out(helper_relay_out),
    .target_out(target_out),
    .serial_tx_out(serial_tx_out),
    .serial_rx_out(serial_rx_out)
);
`default_nettype wire

// ---- sim/testbench.sv ----
// Self-checking bench for the permit, relay and target block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import hprsc_pkg::*;
    logic core_clk_in, rstn_in, ce_in, remote_permit_in, proven_permit_in;
    logic auto_manual_toggle_in, clear_button_in, fault_in, heat_demand_in;
    logic purge_done_in, serial_rx_in, serial_tx_data_in, stuck;
    hprsc_cfg_type cfg_in;
    hprsc_ext_type ext_in;
    logic fire_permit_out, unit_enabled_out, proving_abort_out;
    logic fault_relay_out, helper_relay_out, remote_led_out, manual_led_out;
    logic serial_tx_out, serial_rx_out;
    logic [7:0] target_out;
    int bad_count = 0;
    int comparisons = 0;
    logic [7:0] waits [3] = '{8'h00, 8'h03, 8'hf0};
    logic [15:0] loc [5] = '{16'h6464, 16'h1028, 16'hfff0, 16'h2828, 16'hf0f0};
    // Source, level or network target, expected target
    logic [21:0] ext [9] = '{22'h033328, 22'h0ffff0, 22'h000028, 22'h09998c,
        22'h100028, 22'h1ffff0, 22'h133350, 22'h205050, 22'h200528};
    hprsc_top #(.SEC_CYC(10)) i_dut (.core_clk_in(core_clk_in),
        .rstn_in(rstn_in), .ce_in(ce_in),
        .remote_permit_in(remote_permit_in),
        .proven_permit_in(proven_permit_in),
        .auto_manual_toggle_in(auto_manual_toggle_in),
        .clear_button_in(clear_button_in), .fault_in(fault_in),
        .heat_demand_in(heat_demand_in), .purge_done_in(purge_done_in),
        .cfg_in(cfg_in), .ext_in(ext_in), .serial_rx_in(serial_rx_in),
        .serial_tx_data_in(serial_tx_data_in),
        .fire_permit_out(fire_permit_out),
        .unit_enabled_out(unit_enabled_out),
        .proving_abort_out(proving_abort_out),
        .fault_relay_out(fault_relay_out),
        .helper_relay_out(helper_relay_out),
        .remote_led_out(remote_led_out), .manual_led_out(manual_led_out),
        .target_out(target_out), .serial_tx_out(serial_tx_out),
        .serial_rx_out(serial_rx_out));
    hprsc_field_model i_field (.clk_in(core_clk_in),
        .relay_in(helper_relay_out), .delay_in(8'h0f), .stuck_in(stuck),
        .proven_out(proven_permit_in));
    always #50 core_clk_in = ~core_clk_in;
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk_in);
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic clear;
        clear_button_in = 1'b1;
        cyc(8);
        clear_button_in = 1'b0;
        cyc(8);
    endtask
    task automatic toggle;
        auto_manual_toggle_in = 1'b1;
        cyc(8);
        auto_manual_toggle_in = 1'b0;
        cyc(8);
    endtask
    task automatic results;
        $display("comparisons=%0d mismatches=%0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #800000;
        bad_count++;
        results();
    end
    initial begin
        {core_clk_in, rstn_in, ce_in, remote_permit_in, stuck} = 5'h04;
        {auto_manual_toggle_in, clear_button_in, fault_in} = 3'h0;
        {heat_demand_in, purge_done_in, serial_rx_in, serial_tx_data_in} = 4'h0;
        cfg_in = '{1'b0, HPRSC_SRC_OFFSET, 8'h64, 8'h05, 1'b0};
        ext_in = '0;
        cyc(6);
        rstn_in = 1'b1;
        cyc(20);
        chk({serial_tx_out, serial_rx_out}, 8'h03);
        cfg_in.serial_port_switch = 1'b1;
        cyc(4);
        chk({serial_tx_out, serial_rx_out}, 8'h00);
        $display("test serial done");
        {remote_permit_in, heat_demand_in} = 2'h3;
        cyc(10);
        chk(unit_enabled_out, 8'h01);
        chk({helper_relay_out, fire_permit_out}, 8'h02);
        cyc(50);
        purge_done_in = 1'b1;
        cyc(10);
        chk({fire_permit_out, proving_abort_out}, 8'h02);
        remote_permit_in = 1'b0;
        cyc(10);
        chk({fire_permit_out, unit_enabled_out}, 8'h00);
        remote_permit_in = 1'b1;
        cyc(35);
        chk(fire_permit_out, 1'b1);
        stuck = 1'b1;
        cyc(9);
        chk(fire_permit_out, 1'b0);
        stuck = 1'b0;
        cyc(30);
        {heat_demand_in, purge_done_in} = 2'h0;
        cyc(10);
        chk({helper_relay_out, fire_permit_out}, 8'h00);
        $display("test fire done");
        foreach (waits[i]) begin
            cfg_in.prove_wait = waits[i];
            {stuck, heat_demand_in} = 2'h3;
            cyc(waits[i] == 8'h00 ? 20 : 10 * waits[i] - 5);
            chk(proving_abort_out, waits[i] == 8'h00);
            cyc(20);
            chk({proving_abort_out, fault_relay_out}, 2'h3);
            {stuck, heat_demand_in} = 2'h0;
            clear();
            chk(fault_relay_out, 1'b0);
        end
        $display("test abort done");
        fault_in = 1'b1;
        clear();
        chk(fault_relay_out, 1'b1);
        fault_in = 1'b0;
        cyc(10);
        chk(fault_relay_out, 1'b1);
        clear();
        chk(fault_relay_out, 1'b0);
        $display("test fault done");
        foreach (loc[i]) begin
            cfg_in.local_target = loc[i][15:8];
            cyc(4);
            chk(target_out, loc[i][7:0]);
        end
        cfg_in.local_target = 8'h64;
        toggle();
        chk({manual_led_out, remote_led_out}, 8'h00);
        chk(target_out, 8'h64);
        {ext_in.level_valid, ext_in.net_valid} = 2'h3;
        foreach (ext[i]) begin
            cfg_in.source = hprsc_src_type'(ext[i][21:20]);
            ext_in.level = ext[i][19:8];
            ext_in.net_target = ext[i][15:8];
            cyc(6);
            chk(remote_led_out, 1'b1);
            chk(target_out, ext[i][7:0]);
        end
        ext_in = '0;
        cyc(6);
        chk({remote_led_out, target_out}, 8'h64);
        toggle();
        chk({manual_led_out, remote_led_out}, 8'h02);
        $display("test target done");
        // Enable low freezes the pin pipeline and outputs
        ce_in = 1'b0;
        remote_permit_in = 1'b0;
        cyc(10);
        chk(unit_enabled_out, 8'h01);
        ce_in = 1'b1;
        cyc(10);
        chk(unit_enabled_out, 8'h00);
        $display("test enable done");
        results();
    end
endmodule
`default_nettype wire
